// ==== hdl/hpp_device.sv ====
/*
  Device end of the host port: control, address and data registers
  reached by the host over multiplexed strobes, ready and irq outputs.
  Assumes host pins are synchronous to clk and the host keeps its rules.
*/
// What this block does
// - Host selects register on shared address 3/2
// - Select inputs used only in multiplexed mode
// - Pins serve port only when interface select low
// - Output-off low floats all port outputs
// - Address strobe latches shared lines into address
// - Chip select held through each transfer
// - Host strobes time each transfer
// - Host drives read/write direction per transfer
// - Ready output tells host next transfer possible
// - Per-subsystem interrupt outputs driven low
// - Writing one to irq bit clears it
// - Host interrupts only in multiplexed mode
// - Port reset input resets port and subsystems
// - Mode high: nonmultiplexed, data-only, no irqs
`timescale 1ns/10ps
module hpp_device
  import hpp_pkg::*;
#(
  parameter int MEM_WORDS = 256,
  parameter logic [3:0] BUSY = BUSY_CNT
)(
  input wire logic clk,
  input wire logic rst_n,
  hpp_if.device pins,
  input wire logic port_reset_n,
  input wire logic host_mux_select,
  input wire logic ext_interface_select,
  input wire logic output_off_n,
  input wire logic [ADDR_W-1:0] sep_addr,
  input wire logic irq_a_raise,
  input wire logic irq_b_raise,
  output logic subsys_reset_n,
  output logic [ADDR_W-1:0] port_address_q,
  output logic [DATA_W-1:0] port_control_q
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  localparam int MEM_AW = $clog2(MEM_WORDS);
  logic srst;
  logic active;
  logic mux_mode;
  logic strobe_n;
  logic strobe_q;
  logic strobe_fall;
  logic strobe_rise;
  logic as_q;
  logic as_fall;
  logic [1:0] sel;
  logic wr;
  logic [ADDR_W-1:0] eff_addr;
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic [DATA_W-1:0] port_data_q;
  logic [DATA_W-1:0] rd_q;
  logic drive_q;
  logic [3:0] busy_q;
  logic ready;
  logic irq_en;
  logic [DATA_W-1:0] hd;
  logic data_acc;
  logic ctrl_wr;
  logic addr_load;
  logic addr_step;
  logic [MEM_AW-1:0] mem_idx;
  logic [DATA_W-1:0] rd_next;

  // Raise wins over a clear in the same cycle
  function automatic logic irq_next(input logic cur, input logic raise,
    input logic clr);
    return raise || (cur && !clr);
  endfunction

  assign srst = !rst_n || !port_reset_n;
  assign subsys_reset_n = !srst;
  assign active = !ext_interface_select;
  assign mux_mode = !host_mux_select;
  assign hd = pins.hd_host_o;
  // Either strobe low with chip select makes the internal strobe
  assign strobe_n = pins.port_chip_select_n ||
    (pins.data_strobe_a_n && pins.data_strobe_b_n);
  assign strobe_fall = active && !strobe_n && strobe_q;
  assign strobe_rise = active && strobe_n && !strobe_q;
  assign as_fall = active && mux_mode && !pins.addr_strobe_n && as_q;
  // Nonmultiplexed mode only ever reaches the data register
  assign sel = mux_mode ?
    {pins.reg_select_bit1, pins.reg_select_bit0} : SEL_DATA;
  assign wr = !pins.host_read_write;
  assign eff_addr = mux_mode ? port_address_q : sep_addr;
  assign ready = (busy_q == 4'h0);
  assign irq_en = active && mux_mode;
  assign data_acc = (sel == SEL_DATA) || (sel == SEL_ADDR_AUTO);
  assign ctrl_wr = strobe_fall && wr && sel == SEL_CTRL;
  assign addr_load = strobe_fall && wr && sel == SEL_ADDR;
  // Step after the access, so the word just moved used the old address
  assign addr_step = strobe_rise && sel == SEL_ADDR_AUTO;
  assign mem_idx = eff_addr[MEM_AW-1:0];
  assign rd_next = (sel == SEL_CTRL) ? port_control_q :
    (sel == SEL_ADDR) ? port_address_q : mem[mem_idx];

  // ----------------------------------------------------------------
  // Strobe edges
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      strobe_q <= 1'b1;
      as_q <= 1'b1;
    end
    else
    begin
      strobe_q <= strobe_n;
      as_q <= pins.addr_strobe_n;
    end
  end

  // ----------------------------------------------------------------
  // Busy counter
  // ----------------------------------------------------------------
  // Ready drops for a fixed time after every memory access
  always_ff @(posedge clk)
  begin
    if (srst)
      busy_q <= 4'h0;
    else if (strobe_fall && data_acc)
      busy_q <= BUSY;
    else if (busy_q != 4'h0)
      busy_q <= busy_q - 4'h1;
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      port_control_q <= CTRL_RESET;
    else
    begin
      port_control_q[CTRL_IRQ_A_BIT] <= irq_next(
        port_control_q[CTRL_IRQ_A_BIT], irq_a_raise,
        ctrl_wr && hd[CTRL_IRQ_A_BIT]);
      port_control_q[CTRL_IRQ_B_BIT] <= irq_next(
        port_control_q[CTRL_IRQ_B_BIT], irq_b_raise,
        ctrl_wr && hd[CTRL_IRQ_B_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Address register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      port_address_q <= '0;
    else if (as_fall)
      port_address_q <= hd;
    else if (addr_load)
      port_address_q <= hd;
    else if (addr_step)
      port_address_q <= port_address_q + 16'h1;
  end

  // ----------------------------------------------------------------
  // Read data and bus drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_q <= '0;
      drive_q <= 1'b0;
    end
    else if (strobe_fall)
    begin
      drive_q <= !wr;
      rd_q <= rd_next;
    end
    else if (strobe_rise)
      drive_q <= 1'b0;
  end

  // Data memory behind the data register; no reset, contents undefined
  always_ff @(posedge clk)
  begin
    if (!srst && strobe_fall && wr && data_acc)
      mem[mem_idx] <= hd;
  end
  assign port_data_q = rd_q;

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign pins.hd_dev_o = port_data_q;
  assign pins.hd_dev_oe_n = !(drive_q && active && output_off_n);
  assign pins.port_ready_out = ready;
  assign pins.port_ready_oe_n = !(active && output_off_n);
  assign pins.subsys_a_host_irq_n =
    !(irq_en && port_control_q[CTRL_IRQ_A_BIT]);
  assign pins.subsys_b_host_irq_n =
    !(irq_en && port_control_q[CTRL_IRQ_B_BIT]);
  assign pins.irq_oe_n = !(irq_en && output_off_n);
endmodule

// ==== inc/hpp_pkg.sv ====
/*
  Shared constants for the parallel host port: select codes, control bit
  positions, widths and timing counts.
  Assumes one 40 MHz clock shared by both ends.
*/
package hpp_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int SEL_W = 2;
  // Register select codes carried on shared_addr_3/shared_addr_2
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_ADDR_AUTO = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;
  // Control register bits
  localparam int CTRL_IRQ_A_BIT = 0;
  localparam int CTRL_IRQ_B_BIT = 1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Device busy time after a data access
  localparam int CLK_MHZ = 40;
  localparam int BUSY_NS = 100;
  localparam int BUSY_CYC = (BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] BUSY_CNT = 4'(BUSY_CYC);
  // Controller register offsets (APB byte addresses)
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_WDATA = 8'h04;
  localparam logic [7:0] OFS_RDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  // Command word fields
  localparam int CMD_SEL_LSB = 0;
  localparam int CMD_READ_BIT = 2;
  localparam int CMD_ADDR_BIT = 3;
  // Interrupt status bits
  localparam int IST_DONE = 0;
  localparam int IST_IRQ_A = 1;
  localparam int IST_IRQ_B = 2;
endpackage

// ==== inc/hpp_if.sv ====
/*
  Pin-level link between host and device ends of the host port.
  Assumes the bench resolves the shared data wires from the enables.
*/
`timescale 1ns/10ps
interface hpp_if;
  logic reg_select_bit0;
  logic reg_select_bit1;
  logic port_chip_select_n;
  logic data_strobe_a_n;
  logic data_strobe_b_n;
  logic host_read_write;
  logic addr_strobe_n;
  logic [15:0] hd_host_o;
  logic hd_host_oe_n;
  logic [15:0] hd_dev_o;
  logic hd_dev_oe_n;
  logic port_ready_out;
  logic port_ready_oe_n;
  logic subsys_a_host_irq_n;
  logic subsys_b_host_irq_n;
  logic irq_oe_n;

  modport device (
    input reg_select_bit0, reg_select_bit1, port_chip_select_n,
    input data_strobe_a_n, data_strobe_b_n, host_read_write,
    input addr_strobe_n, hd_host_o, hd_host_oe_n,
    output hd_dev_o, hd_dev_oe_n, port_ready_out, port_ready_oe_n,
    output subsys_a_host_irq_n, subsys_b_host_irq_n, irq_oe_n
  );
  modport host (
    output reg_select_bit0, reg_select_bit1, port_chip_select_n,
    output data_strobe_a_n, data_strobe_b_n, host_read_write,
    output addr_strobe_n, hd_host_o, hd_host_oe_n,
    input hd_dev_o, hd_dev_oe_n, port_ready_out, port_ready_oe_n,
    input subsys_a_host_irq_n, subsys_b_host_irq_n, irq_oe_n
  );
endinterface

// ==== hdl/hpp_host.sv ====
/*
  Host end of the port: an APB slave takes commands and runs one port
  transfer per command on the pins, waiting for ready.
  Assumes the device end shares clk; pins are synchronous.
*/
`timescale 1ns/10ps
module hpp_host
  import hpp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  hpp_if.host pins,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  typedef enum logic [2:0] {ST_IDLE, ST_WAITRDY, ST_SETUP, ST_STROBE,
    ST_END} hpp_state_e;
  hpp_state_e st_q;
  logic [31:0] cmd_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [2:0] ist_q;
  logic [2:0] ien_q;
  logic [1:0] irq_n_q;
  logic [3:0] cnt_q;
  logic wr_acc;
  logic rd_acc;
  logic start;
  logic busy;
  logic [2:0] ev;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign busy = (st_q != ST_IDLE);
  assign start = wr_acc && paddr == OFS_CMD && !busy;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = |(ist_q & ien_q);
  assign ev[IST_DONE] = (st_q == ST_END);
  assign ev[IST_IRQ_A] = irq_n_q[0] && !pins.subsys_a_host_irq_n &&
    !pins.irq_oe_n;
  assign ev[IST_IRQ_B] = irq_n_q[1] && !pins.subsys_b_host_irq_n &&
    !pins.irq_oe_n;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      unique case (paddr)
        OFS_CMD: prdata <= cmd_q;
        OFS_WDATA: prdata <= {16'h0, wdata_q};
        OFS_RDATA: prdata <= {16'h0, rdata_q};
        OFS_STATUS: prdata <= {30'h0, pins.port_ready_out, busy};
        OFS_IRQ_STAT: prdata <= {29'h0, ist_q};
        OFS_IRQ_EN: prdata <= {29'h0, ien_q};
        default: prdata <= 32'h0;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wdata_q <= 16'h0;
      ien_q <= 3'h0;
      ist_q <= 3'h0;
      irq_n_q <= 2'h3;
    end
    else
    begin
      irq_n_q <= {pins.subsys_b_host_irq_n, pins.subsys_a_host_irq_n};
      if (wr_acc && paddr == OFS_WDATA)
        wdata_q <= pwdata[15:0];
      if (wr_acc && paddr == OFS_IRQ_EN)
        ien_q <= pwdata[2:0];
      // Set wins over clear
      ist_q <= ev | (ist_q & ~((wr_acc && paddr == OFS_IRQ_CLR) ?
        pwdata[2:0] : 3'h0));
    end
  end

  // ----------------------------------------------------------------
  // Port transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      cmd_q <= 32'h0;
      rdata_q <= 16'h0;
      cnt_q <= 4'h0;
    end
    else
      unique case (st_q)
        ST_IDLE:
          if (start)
          begin
            cmd_q <= pwdata;
            st_q <= ST_WAITRDY;
          end
        ST_WAITRDY:
          if (pins.port_ready_out)
            st_q <= ST_SETUP;
        ST_SETUP:
        begin
          st_q <= ST_STROBE;
          cnt_q <= 4'h2;
        end
        ST_STROBE:
          if (cnt_q == 4'h0)
          begin
            rdata_q <= pins.hd_dev_o;
            st_q <= ST_END;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        ST_END:
          st_q <= ST_IDLE;
      endcase
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign pins.port_chip_select_n = !(st_q == ST_SETUP ||
    st_q == ST_STROBE);
  assign {pins.reg_select_bit1, pins.reg_select_bit0} =
    cmd_q[CMD_SEL_LSB +: 2];
  assign pins.host_read_write = cmd_q[CMD_READ_BIT];
  // Read strobe on a, write strobe on b, as a host bus wires them
  assign pins.data_strobe_a_n = !(st_q == ST_STROBE &&
    !cmd_q[CMD_ADDR_BIT] && cmd_q[CMD_READ_BIT]);
  assign pins.data_strobe_b_n = !(st_q == ST_STROBE &&
    !cmd_q[CMD_ADDR_BIT] && !cmd_q[CMD_READ_BIT]);
  assign pins.addr_strobe_n = !(st_q == ST_STROBE &&
    cmd_q[CMD_ADDR_BIT]);
  assign pins.hd_host_o = wdata_q;
  assign pins.hd_host_oe_n = !(busy && (!cmd_q[CMD_READ_BIT] ||
    cmd_q[CMD_ADDR_BIT]));
endmodule

// ==== dv/hpp_props.sv ====
/*
  Pin-level assertions for the host port link.
  Assumes one clk; instantiated beside the interface by the bench.
*/
`timescale 1ns/10ps
module hpp_props
  import hpp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_select_bit0,
  input wire logic reg_select_bit1,
  input wire logic port_chip_select_n,
  input wire logic data_strobe_a_n,
  input wire logic data_strobe_b_n,
  input wire logic host_read_write,
  input wire logic hd_dev_oe_n,
  input wire logic port_ready_out,
  input wire logic port_ready_oe_n,
  input wire logic subsys_a_host_irq_n,
  input wire logic subsys_b_host_irq_n,
  input wire logic irq_oe_n,
  input wire logic host_mux_select,
  input wire logic ext_interface_select,
  input wire logic output_off_n
);
  // Either strobe low counts as a strobe
  wire stb_n = data_strobe_a_n & data_strobe_b_n;
  wire data_sel = host_mux_select
    || ({reg_select_bit1, reg_select_bit0} inside {SEL_DATA, SEL_ADDR_AUTO});
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ready_busy: assert property (
    $fell(stb_n) && !port_chip_select_n && !ext_interface_select
    && data_sel |-> ##[1:3] !port_ready_out)
    else $error("ready did not drop after data access");
  a_ready_back: assert property (
    $fell(port_ready_out) |-> ##[1:8] port_ready_out)
    else $error("ready stayed low too long");
  a_host_waits: assert property (
    $fell(stb_n) |-> port_ready_out)
    else $error("strobe began while not ready");
  a_cs_held: assert property (
    !stb_n |-> !port_chip_select_n)
    else $error("strobe without chip select");
  a_strobe_len: assert property (
    $fell(stb_n) |-> !stb_n[*3] ##1 stb_n)
    else $error("strobe length wrong");
  a_rw_stable: assert property (
    !stb_n && !$past(stb_n) |-> $stable(host_read_write))
    else $error("direction changed inside strobe");
  a_irq_nonmux: assert property (
    host_mux_select |-> subsys_a_host_irq_n && subsys_b_host_irq_n)
    else $error("host irq in nonmultiplexed mode");
  a_off_float: assert property (
    !output_off_n |-> hd_dev_oe_n && port_ready_oe_n && irq_oe_n)
    else $error("output driven while off");
  a_ext_float: assert property (
    ext_interface_select |-> hd_dev_oe_n && port_ready_oe_n && irq_oe_n)
    else $error("port output driven in memory mode");

  c_read: cover property ($fell(stb_n) && host_read_write);
  c_irq: cover property ($fell(subsys_a_host_irq_n));
  c_busy: cover property ($fell(port_ready_out));
endmodule

// ==== dv/host_port_pin_interface_tb.sv ====
/*
  Bench: APB master into the host end, model memory compared per result.
  Assumes both ends share clk and meet in hpp_if.
*/
`timescale 1ns/10ps
module host_port_pin_interface_tb
  import hpp_pkg::*;
;
  logic clk = 0, rst_n = 0, port_reset_n = 1, host_mux_select = 0;
  logic ext_interface_select = 0, output_off_n = 1;
  logic irq_a_raise = 0, irq_b_raise = 0, psel = 0, penable = 0;
  logic pwrite = 0, pready, pslverr, irq, subsys_reset_n;
  logic [15:0] sep_addr = 16'h0, port_address_q, port_control_q, a, d;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] mem [int];
  int bad_count = 0, checked = 0, cyc = 0, maddr;
  hpp_if pins();
  hpp_device hpp_device_inst (.clk(clk), .rst_n(rst_n), .pins(pins),
    .port_reset_n(port_reset_n), .host_mux_select(host_mux_select),
    .ext_interface_select(ext_interface_select),
    .output_off_n(output_off_n), .sep_addr(sep_addr),
    .irq_a_raise(irq_a_raise), .irq_b_raise(irq_b_raise),
    .subsys_reset_n(subsys_reset_n), .port_address_q(port_address_q),
    .port_control_q(port_control_q));
  hpp_host hpp_host_inst (.clk(clk), .rst_n(rst_n), .pins(pins),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  hpp_props hpp_props_inst (.clk(clk), .rst_n(rst_n),
    .reg_select_bit0(pins.reg_select_bit0),
    .reg_select_bit1(pins.reg_select_bit1),
    .port_chip_select_n(pins.port_chip_select_n),
    .data_strobe_a_n(pins.data_strobe_a_n),
    .data_strobe_b_n(pins.data_strobe_b_n),
    .host_read_write(pins.host_read_write),
    .hd_dev_oe_n(pins.hd_dev_oe_n), .port_ready_out(pins.port_ready_out),
    .port_ready_oe_n(pins.port_ready_oe_n),
    .subsys_a_host_irq_n(pins.subsys_a_host_irq_n),
    .subsys_b_host_irq_n(pins.subsys_b_host_irq_n),
    .irq_oe_n(pins.irq_oe_n), .host_mux_select(host_mux_select),
    .ext_interface_select(ext_interface_select),
    .output_off_n(output_off_n));

  always #12.5 clk = ~clk;

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard: whole run needs well under this
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop;
    end
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", pslverr, 0);
    psel <= 0;
    penable <= 0;
  endtask

  // One port transfer; waits for done, then clears it
  task xfer(input logic [1:0] s, input logic rd, input logic as,
            input logic [15:0] wd);
    apb(1, OFS_WDATA, {16'h0, wd});
    apb(1, OFS_CMD, {28'h0, as, rd, s});
    do apb(0, OFS_IRQ_STAT, 32'h0); while (r[IST_DONE] !== 1'b1);
    apb(1, OFS_IRQ_CLR, 32'h1 << IST_DONE);
    if (rd)
      apb(0, OFS_RDATA, 32'h0);
  endtask

  task pulse(input logic b);
    if (b) irq_b_raise <= 1; else irq_a_raise <= 1;
    @(posedge clk);
    irq_a_raise <= 0;
    irq_b_raise <= 0;
    @(posedge clk);
    // Look half a cycle later, once the raised flag has settled
    @(negedge clk);
  endtask

  initial
  begin
    void'($urandom(15028));
    repeat (16) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    #1 chk("ctrl", port_control_q, CTRL_RESET);
    chk("irqa", pins.subsys_a_host_irq_n, 1);
    apb(0, 8'h1c, 32'h0);
    chk("unmapped", r, 0);
    apb(0, OFS_STATUS, 32'h0);
    chk("status", r, 32'h2);
    // Address strobe cycle latches the address only
    a = 16'($urandom_range(0, 200));
    xfer(SEL_DATA, 0, 1, a);
    maddr = a;
    chk("addr", port_address_q, a);
    for (int i = 0; i < 4; i++)
    begin
      d = 16'($urandom);
      xfer(SEL_ADDR_AUTO, 0, 0, d);
      mem[maddr] = d;
      maddr++;
    end
    chk("auto", port_address_q, maddr);
    for (int k = 0; k < 4; k++)
    begin
      xfer(SEL_ADDR, 0, 0, a + 16'(k));
      xfer(SEL_DATA, 1, 0, 16'h0);
      chk("rdata", r[15:0], mem[a + k]);
    end
    xfer(SEL_ADDR, 1, 0, 16'h0);
    chk("addr_rd", r[15:0], a + 16'h3);
    // Auto-increment reads step the address after each word
    xfer(SEL_ADDR, 0, 0, a);
    for (int k = 0; k < 2; k++)
    begin
      xfer(SEL_ADDR_AUTO, 1, 0, 16'h0);
      chk("auto_rd", r[15:0], mem[a + k]);
    end
    xfer(SEL_ADDR, 1, 0, 16'h0);
    chk("addr_inc", r[15:0], a + 16'h2);
    // Interrupt A: raise, mask, clear over the port
    apb(1, OFS_IRQ_EN, 32'h1 << IST_IRQ_A);
    pulse(0);
    chk("irqa_lo", pins.subsys_a_host_irq_n, 0);
    chk("hirq", irq, 1);
    apb(1, OFS_IRQ_EN, 32'h0);
    @(negedge clk);
    chk("masked", irq, 0);
    xfer(SEL_CTRL, 0, 0, 16'h1 << CTRL_IRQ_A_BIT);
    chk("irqa_clr", pins.subsys_a_host_irq_n, 1);
    apb(0, OFS_IRQ_STAT, 32'h0);
    chk("stat", r & 32'h6, 32'h2);
    apb(1, OFS_IRQ_CLR, 32'h6);
    apb(0, OFS_IRQ_STAT, 32'h0);
    chk("stat_clr", r, 0);
    pulse(1);
    chk("irqb_lo", pins.subsys_b_host_irq_n, 0);
    xfer(SEL_CTRL, 0, 0, 16'h1 << CTRL_IRQ_B_BIT);
    chk("irqb_clr", pins.subsys_b_host_irq_n, 1);
    // Nonmultiplexed: select ignored, data to sep_addr, no irqs
    host_mux_select <= 1;
    sep_addr <= 16'($urandom_range(0, 255));
    d = 16'($urandom);
    pulse(1);
    chk("nomux_irq", pins.subsys_b_host_irq_n, 1);
    xfer(SEL_CTRL, 0, 0, d);
    mem[sep_addr] = d;
    host_mux_select <= 0;
    xfer(SEL_CTRL, 0, 0, 16'h3);
    xfer(SEL_ADDR, 0, 0, sep_addr);
    xfer(SEL_DATA, 1, 0, 16'h0);
    chk("nomux_data", r[15:0], mem[sep_addr]);
    output_off_n <= 0;
    @(negedge clk);
    chk("off", {pins.hd_dev_oe_n, pins.port_ready_oe_n,
      pins.irq_oe_n}, 3'h7);
    @(posedge clk);
    output_off_n <= 1;
    ext_interface_select <= 1;
    @(negedge clk);
    chk("ext", {pins.hd_dev_oe_n, pins.port_ready_oe_n,
      pins.irq_oe_n}, 3'h7);
    @(posedge clk);
    ext_interface_select <= 0;
    pulse(0);
    chk("irqa_pre", pins.subsys_a_host_irq_n, 0);
    @(posedge clk);
    port_reset_n <= 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("subrst", subsys_reset_n, 0);
    chk("ctrl_rst", port_control_q, CTRL_RESET);
    @(posedge clk);
    port_reset_n <= 1;
    // Port must work again straight after its own reset
    xfer(SEL_CTRL, 1, 0, 16'h0);
    chk("ctrl_rd", r[15:0], CTRL_RESET);
    report_and_stop;
  end
endmodule
